/* rtl/alds_params.svh */
`ifndef ALDS_PARAMS_SVH
`define ALDS_PARAMS_SVH

// bus addressing
`define ALDS_SLAVE_ADDR 7'h6C
`define ALDS_SUB_CTRL_A 7'h01
`define ALDS_SUB_CTRL_B 7'h02
`define ALDS_SUB_TEST 7'h15
`define ALDS_SUB_AUTOINC 7

// control word reset values: standby, muted, diagnosis off
`define ALDS_CTRL_A_RST 8'h00
`define ALDS_CTRL_B_RST 8'h00

// control word a fields
`define ALDS_A_OFFS_EN 5
`define ALDS_A_DIAG_EN 6
`define ALDS_A_ONESHOT 7

// control word b fields
`define ALDS_B_CUR_EN 2
`define ALDS_B_PLAY 4
`define ALDS_B_IND_OFFS 5
`define ALDS_B_CUR_THR 7

// status byte fields per channel
`define ALDS_S_GND 0
`define ALDS_S_VCC 1
`define ALDS_S_OPEN 2
`define ALDS_S_LOAD 3
`define ALDS_S_PERM 4
`define ALDS_S_CUR 5

// timing
`define ALDS_CLK_MHZ 250
`define ALDS_ACQ_TIME_MS 100
`define ALDS_ACQ_CYCLES (`ALDS_ACQ_TIME_MS * 1000 * `ALDS_CLK_MHZ)

`define ALDS_NUM_BYTES 4

`endif

/* rtl/alds_pkg.sv */
`default_nettype none
package alds_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_SUB,
		ST_ACK_SUB,
		ST_WR,
		ST_ACK_WR,
		ST_RD,
		ST_RD_ACK
	} alds_state_e;

	typedef logic [7:0] alds_byte_t;
endpackage : alds_pkg
`default_nettype wire

/* rtl/alds_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module alds_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] meta_q;

	// meta_q feeds only the second stage
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			meta_q <= INIT;
			Q <= INIT;
		end else begin
			meta_q <= D;
			Q <= meta_q;
		end
	end
endmodule : alds_sync
`default_nettype wire

/* rtl/alds_top.sv */
// Behaviour
// - status byte three bits 0..4: gnd, vcc, open/offset, short load, permanent flag.
// - bit5 shows low peak current only while current detection is enabled.
// - status byte three bit6 echoes diagnostic cycle enable of control word a.
// - status byte three bit7 echoes standby-off bit of control word b.
// - status byte four mirrors channel layout bits 0..5; bits 6,7 read zero.
// - turn-on diagnosis checks short to gnd, vcc, output short, open speaker.
// - control word a bit7 picks one-shot (1) or repeat (0) turn-on mode.
// - in repeat mode, with diagnosis enabled and standby off, every read restarts turn-on diagnosis.
// - permanent diagnosis runs regardless of the diagnosis enable bit.
// - a bare read returns permanent diagnosis results without prior write.
// - a removed permanent fault still shows on the next read.
// - permanent diagnosis takes over automatically when turn-on diagnosis ends.
// - offset result is live at each read, never latched.
// - offset fault flagged beyond plus or minus two volts threshold.
// - indicator pin carries clip by default, offset when selected by write.
// - status byte one bit7 reports thermal warning near shutdown.
// - device answers only its fixed slave address.
// - a read returns the four status bytes, channel one first.
// - control word b bit2 enables current detection, bit7 selects threshold.
`timescale 1ns/1ns
`default_nettype none
`include "alds_params.svh"
module alds_top
	import alds_pkg::*;
#(
	parameter int unsigned ACQ_CYCLES = `ALDS_ACQ_CYCLES
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic [3:0] FLT_GND,
	input wire logic [3:0] FLT_VCC,
	input wire logic [3:0] FLT_LOAD,
	input wire logic [3:0] FLT_OPEN,
	input wire logic [3:0] FLT_OFFS,
	input wire logic [3:0] CUR_LOW,
	input wire logic THERM_WARN,
	input wire logic CLIP_DET,
	output logic CLIP_INDICATOR,
	output logic DIAG_RUN,
	output logic [7:0] CONTROL_WORD_A,
	output logic [7:0] CONTROL_WORD_B
);
	localparam logic [31:0] ACQ_LAST = 32'(ACQ_CYCLES - 1);

	default clocking cb_main @(posedge CLK); endclocking
	default disable iff (!RST_N);

	logic scl_s, sda_s, scl_d_q, sda_d_q;
	logic [3:0] gnd_s, vcc_s, load_s, open_s, offs_s, cur_s;
	logic therm_s, clip_s;

	alds_sync #(.W(2), .INIT(2'b11)) u_sync_bus (
		.CLK(CLK),
		.RST_N(RST_N),
		.D({SCL_I, SDA_I}),
		.Q({scl_s, sda_s})
	);

	alds_sync #(.W(26), .INIT('0)) u_sync_ana (
		.CLK(CLK),
		.RST_N(RST_N),
		.D({FLT_GND, FLT_VCC, FLT_LOAD, FLT_OPEN, FLT_OFFS, CUR_LOW, THERM_WARN, CLIP_DET}),
		.Q({gnd_s, vcc_s, load_s, open_s, offs_s, cur_s, therm_s, clip_s})
	);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s & ~scl_d_q;
	assign scl_fall = ~scl_s & scl_d_q;
	assign bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign bus_stop = scl_s & scl_d_q & ~sda_d_q & sda_s;

	alds_state_e state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] sh_q, tx_q, ptr_q;
	logic rw_q, nack_q, oe_q;
	logic [2:0] idx_q;
	logic [7:0] ctrl_a_q, ctrl_b_q;
	alds_byte_t snap_q [`ALDS_NUM_BYTES];
	alds_byte_t db [`ALDS_NUM_BYTES];

	logic wr_stb, read_start;
	assign wr_stb = scl_fall && (state_q == ST_WR) && (bit_cnt_q == 4'h8);
	assign read_start = scl_fall && (state_q == ST_ACK_ADDR) && rw_q;

	// bus slave, open-drain data line
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			oe_q <= 1'b0;
			idx_q <= 3'h0;
		end else if (bus_start) begin
			state_q <= ST_ADDR;
			bit_cnt_q <= 4'h0;
			oe_q <= 1'b0;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			oe_q <= 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				ST_ADDR, ST_SUB, ST_WR: begin
					sh_q <= {sh_q[6:0], sda_s};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
				ST_RD_ACK: nack_q <= sda_s;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (bit_cnt_q == 4'h8) begin
						if (sh_q[7:1] == `ALDS_SLAVE_ADDR) begin
							state_q <= ST_ACK_ADDR;
							rw_q <= sh_q[0];
							oe_q <= 1'b1;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_ACK_ADDR: begin
					bit_cnt_q <= 4'h0;
					if (rw_q) begin
						state_q <= ST_RD;
						tx_q <= db[0];
						oe_q <= ~db[0][7];
						idx_q <= 3'h1;
					end else begin
						state_q <= ST_SUB;
						oe_q <= 1'b0;
					end
				end
				ST_SUB: begin
					if (bit_cnt_q == 4'h8) begin
						state_q <= ST_ACK_SUB;
						ptr_q <= sh_q;
						oe_q <= 1'b1;
					end
				end
				ST_ACK_SUB, ST_ACK_WR: begin
					state_q <= ST_WR;
					bit_cnt_q <= 4'h0;
					oe_q <= 1'b0;
					if (state_q == ST_ACK_WR && ptr_q[`ALDS_SUB_AUTOINC]) begin
						ptr_q[6:0] <= ptr_q[6:0] + 7'h01;
					end
				end
				ST_WR: begin
					if (bit_cnt_q == 4'h8) begin
						state_q <= ST_ACK_WR;
						oe_q <= 1'b1;
					end
				end
				ST_RD: begin
					if (bit_cnt_q == 4'h7) begin
						state_q <= ST_RD_ACK;
						oe_q <= 1'b0;
					end else begin
						tx_q <= {tx_q[6:0], 1'b0};
						oe_q <= ~tx_q[6];
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				ST_RD_ACK: begin
					if (nack_q) begin
						state_q <= ST_IDLE;
					end else begin
						state_q <= ST_RD;
						bit_cnt_q <= 4'h0;
						idx_q <= idx_q + 3'h1;
						if (idx_q < 3'(`ALDS_NUM_BYTES)) begin
							tx_q <= snap_q[idx_q[1:0]];
							oe_q <= ~snap_q[idx_q[1:0]][7];
						end else begin
							tx_q <= 8'h00;
							oe_q <= 1'b1;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign SDA_O = 1'b0;
	assign SDA_OE = oe_q;

	// control words; other sub-addresses, the test one among them, have no effect
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_a_q <= `ALDS_CTRL_A_RST;
			ctrl_b_q <= `ALDS_CTRL_B_RST;
		end else if (wr_stb) begin
			if (ptr_q[6:0] == `ALDS_SUB_CTRL_A) begin
				ctrl_a_q <= sh_q;
			end
			if (ptr_q[6:0] == `ALDS_SUB_CTRL_B) begin
				ctrl_b_q <= sh_q;
			end
		end
	end

	assign CONTROL_WORD_A = ctrl_a_q;
	assign CONTROL_WORD_B = ctrl_b_q;

	// turn-on diagnosis sequencer
	logic on_run_q, done_q, perm_q, to_pend_q;
	logic [31:0] acq_cnt_q;
	logic start_play, start_rep, diag_start, acq_end;

	assign start_play = wr_stb && (ptr_q[6:0] == `ALDS_SUB_CTRL_B) && sh_q[`ALDS_B_PLAY]
		&& !ctrl_b_q[`ALDS_B_PLAY] && ctrl_a_q[`ALDS_A_DIAG_EN];
	assign start_rep = read_start && ctrl_a_q[`ALDS_A_DIAG_EN] && !ctrl_a_q[`ALDS_A_ONESHOT]
		&& ctrl_b_q[`ALDS_B_PLAY];
	assign diag_start = start_play || start_rep;
	assign acq_end = on_run_q && (acq_cnt_q == ACQ_LAST);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			on_run_q <= 1'b0;
			done_q <= 1'b0;
			perm_q <= 1'b1;
			acq_cnt_q <= 32'h0000_0000;
		end else if (diag_start) begin
			on_run_q <= 1'b1;
			done_q <= 1'b0;
			perm_q <= 1'b0;
			acq_cnt_q <= 32'h0000_0000;
		end else if (acq_end) begin
			on_run_q <= 1'b0;
			done_q <= 1'b1;
			perm_q <= 1'b1;
		end else if (on_run_q) begin
			acq_cnt_q <= acq_cnt_q + 32'h0000_0001;
		end
	end

	// turn-on result is reported once, then permanent results follow
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			to_pend_q <= 1'b0;
		end else if (acq_end && !diag_start) begin
			to_pend_q <= 1'b1;
		end else if (read_start || diag_start) begin
			to_pend_q <= 1'b0;
		end
	end

	assign DIAG_RUN = on_run_q;

	logic rep_perm;
	logic [5:0] ch_bits [4];
	logic [3:0] to_lat_q [4];
	logic [2:0] pm_lat_q [4];
	assign rep_perm = perm_q && !to_pend_q;

	for (genvar c = 0; c < 4; c++) begin : g_ch
		logic [3:0] to_live;
		logic [2:0] pm_live;
		assign to_live = {load_s[c], open_s[c], vcc_s[c], gnd_s[c]};
		assign pm_live = {load_s[c], vcc_s[c], gnd_s[c]};

		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				to_lat_q[c] <= 4'h0;
			end else if (diag_start) begin
				to_lat_q[c] <= 4'h0;
			end else if (on_run_q) begin
				to_lat_q[c] <= to_lat_q[c] | to_live;
			end
		end

		// sticky faults: re-armed from live state at each read, cleared by a read during turn-on, set wins
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				pm_lat_q[c] <= 3'h0;
			end else if (read_start) begin
				pm_lat_q[c] <= perm_q ? pm_live : 3'h0;
			end else if (perm_q) begin
				pm_lat_q[c] <= pm_lat_q[c] | pm_live;
			end
		end

		always_comb begin
			ch_bits[c][`ALDS_S_GND] = rep_perm ? pm_lat_q[c][0] : to_lat_q[c][0];
			ch_bits[c][`ALDS_S_VCC] = rep_perm ? pm_lat_q[c][1] : to_lat_q[c][1];
			ch_bits[c][`ALDS_S_OPEN] = rep_perm ? (offs_s[c] && ctrl_a_q[`ALDS_A_OFFS_EN])
				: to_lat_q[c][2];
			ch_bits[c][`ALDS_S_LOAD] = rep_perm ? pm_lat_q[c][2] : to_lat_q[c][3];
			ch_bits[c][`ALDS_S_PERM] = rep_perm;
			ch_bits[c][`ALDS_S_CUR] = cur_s[c] && ctrl_b_q[`ALDS_B_CUR_EN];
		end
	end

	assign db[0] = {therm_s, done_q, ch_bits[0]};
	assign db[1] = {ctrl_a_q[`ALDS_A_OFFS_EN], ctrl_b_q[`ALDS_B_CUR_EN], ch_bits[1]};
	assign db[2] = {ctrl_b_q[`ALDS_B_PLAY], ctrl_a_q[`ALDS_A_DIAG_EN], ch_bits[2]};
	assign db[3] = {2'b00, ch_bits[3]};

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < `ALDS_NUM_BYTES; i++) begin
				snap_q[i] <= 8'h00;
			end
		end else if (read_start) begin
			for (int i = 0; i < `ALDS_NUM_BYTES; i++) begin
				snap_q[i] <= db[i];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			CLIP_INDICATOR <= 1'b0;
		end else begin
			CLIP_INDICATOR <= ctrl_b_q[`ALDS_B_IND_OFFS] ? |offs_s : clip_s;
		end
	end

	property p_addr_match;
		(state_q == ST_ADDR) ##1 (state_q == ST_ACK_ADDR) |-> $past(sh_q[7:1]) == `ALDS_SLAVE_ADDR;
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("ack on foreign address");
	property p_echo_diag;
		read_start |=> snap_q[2][6] == $past(ctrl_a_q[`ALDS_A_DIAG_EN]);
	endproperty
	a_echo_diag: assert property (p_echo_diag) else $error("byte3 bit6 echo wrong");
	property p_echo_play;
		read_start |=> snap_q[2][7] == $past(ctrl_b_q[`ALDS_B_PLAY]);
	endproperty
	a_echo_play: assert property (p_echo_play) else $error("byte3 bit7 echo wrong");
	property p_b4_high;
		read_start |=> snap_q[3][7:6] == 2'b00;
	endproperty
	a_b4_high: assert property (p_b4_high) else $error("byte4 upper bits set");
	property p_cur_gate;
		read_start && !ctrl_b_q[`ALDS_B_CUR_EN] |=> !snap_q[2][5] && !snap_q[3][5];
	endproperty
	a_cur_gate: assert property (p_cur_gate) else $error("current bit while disabled");
	property p_acq_done;
		acq_end && !diag_start |=> !on_run_q && perm_q && done_q;
	endproperty
	a_acq_done: assert property (p_acq_done) else $error("no switch to permanent");
	property p_repeat;
		read_start && ctrl_a_q[6] && !ctrl_a_q[7] && ctrl_b_q[4] |=> on_run_q && acq_cnt_q == 0;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat read did not restart");
	property p_oneshot;
		read_start && ctrl_a_q[`ALDS_A_ONESHOT] && !on_run_q |=> !on_run_q;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot read restarted");
	property p_sticky;
		read_start && rep_perm && pm_lat_q[2][0] |=> snap_q[2][0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky fault lost");
	property p_offs_live;
		read_start && rep_perm && ctrl_a_q[5] |=> snap_q[2][2] == $past(offs_s[2]);
	endproperty
	a_offs_live: assert property (p_offs_live) else $error("offset not live");
	property p_ind_clip;
		!ctrl_b_q[`ALDS_B_IND_OFFS] ##1 !ctrl_b_q[`ALDS_B_IND_OFFS] |-> CLIP_INDICATOR == $past(clip_s);
	endproperty
	a_ind_clip: assert property (p_ind_clip) else $error("indicator not clip");

	c_read: cover property (read_start);
	c_write_b: cover property (wr_stb && ptr_q[6:0] == `ALDS_SUB_CTRL_B);
	c_acq: cover property (acq_end);
	c_rep: cover property (start_rep);
endmodule : alds_top
`default_nettype wire

/* tb/alds_host.sv */
`timescale 1ns/1ns
`default_nettype none
module alds_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_oe
);
	// bus idles released, clock parked high
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// one quarter of a 128 ns bit cell
	task automatic ph();
		repeat (8) @(posedge clk);
	endtask : ph
	task automatic start();
		sda_oe <= 1'b0;
		ph();
		scl <= 1'b1;
		ph();
		sda_oe <= 1'b1;
		ph();
		scl <= 1'b0;
		ph();
	endtask : start
	task automatic stop();
		sda_oe <= 1'b1;
		ph();
		scl <= 1'b1;
		ph();
		sda_oe <= 1'b0;
		ph();
	endtask : stop
	// data held across the whole high phase, sampled mid-high
	task automatic bitx(input logic b, output logic r);
		sda_oe <= ~b;
		ph();
		scl <= 1'b1;
		ph();
		r = sda;
		ph();
		scl <= 1'b0;
		ph();
	endtask : bitx
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		ack = ~r;
	endtask : wr
	// last byte is answered with a nack
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
	endtask : rd
endmodule : alds_host
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst_n;
	logic scl;
	logic sda_oe_m;
	logic sda_oe_d;
	logic sda_o;
	logic [3:0] f_gnd, f_vcc, f_load, f_open, f_offs, cur_low;
	logic therm;
	logic clip;
	logic clip_ind;
	logic diag_run;
	logic [7:0] cwa, cwb;
	int fail_count = 0;
	int n_tests = 0;
	// open drain with pull-up
	wire sda = ~sda_oe_m & (sda_oe_d ? sda_o : 1'b1);

	always #2 clk = ~clk;

	alds_top #(.ACQ_CYCLES(2000)) u_alds_top (.CLK(clk), .RST_N(rst_n), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe_d), .FLT_GND(f_gnd), .FLT_VCC(f_vcc),
		.FLT_LOAD(f_load), .FLT_OPEN(f_open), .FLT_OFFS(f_offs), .CUR_LOW(cur_low),
		.THERM_WARN(therm), .CLIP_DET(clip), .CLIP_INDICATOR(clip_ind),
		.DIAG_RUN(diag_run), .CONTROL_WORD_A(cwa), .CONTROL_WORD_B(cwb));
	alds_host u_alds_host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(sda_oe_m));

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// auto-increment write of both control words
	task automatic put(input logic [7:0] a, input logic [7:0] b);
		logic k;
		u_alds_host.start();
		u_alds_host.wr(8'hD8, k);
		chk(16'(k), 16'h0001);
		u_alds_host.wr(8'h81, k);
		u_alds_host.wr(a, k);
		u_alds_host.wr(b, k);
		u_alds_host.stop();
		chk({cwa, cwb}, {a, b});
	endtask : put
	// bare read of the four status bytes, first byte in the top
	task automatic get(output logic [31:0] d);
		logic k;
		logic [7:0] b;
		u_alds_host.start();
		u_alds_host.wr(8'hD9, k);
		for (int i = 3; i >= 0; i--) begin
			u_alds_host.rd(i == 0, b);
			d = {d[23:0], b};
		end
		u_alds_host.stop();
	endtask : get
	task automatic wait_run(input logic v);
		int i;
		for (i = 0; i < 4000 && diag_run !== v; i++) begin
			@(posedge clk);
		end
		if (i == 4000) begin
			fail_count++;
			report_and_stop();
		end
	endtask : wait_run

	task automatic s_bare();
		logic [31:0] d;
		@(posedge clk);
		f_gnd <= 4'h4;
		f_vcc <= 4'h8;
		get(d);
		chk(d[15:0], 16'h1112);
		@(posedge clk);
		f_gnd <= 4'h0;
		f_vcc <= 4'h0;
		get(d);
		chk(d[15:0], 16'h1112);
		get(d);
		chk(d[15:0], 16'h1010);
	endtask : s_bare
	task automatic s_refuse();
		logic k;
		u_alds_host.start();
		u_alds_host.wr(8'hDA, k);
		chk(16'(k), 16'h0000);
		u_alds_host.stop();
		u_alds_host.start();
		u_alds_host.wr(8'hD8, k);
		u_alds_host.wr(8'h03, k);
		u_alds_host.wr(8'hFF, k);
		u_alds_host.stop();
		chk({cwa, cwb}, 16'h0000);
	endtask : s_refuse
	task automatic s_cur();
		logic [31:0] d;
		@(posedge clk);
		put(8'h06, 8'h94);
		cur_low <= 4'hC;
		therm <= 1'b1;
		cyc(16);
		get(d);
		chk(d[15:0], 16'hB030);
		chk(16'(d[31]), 16'h0001);
		put(8'h00, 8'h00);
		get(d);
		chk(d[15:0], 16'h1010);
		cur_low <= 4'h0;
		therm <= 1'b0;
	endtask : s_cur
	task automatic s_offs();
		logic [31:0] d;
		@(posedge clk);
		clip <= 1'b1;
		cyc(6);
		chk(16'(clip_ind), 16'h0001);
		put(8'h20, 8'h20);
		clip <= 1'b0;
		f_offs <= 4'h4;
		cyc(6);
		chk(16'(clip_ind), 16'h0001);
		get(d);
		chk(d[15:0], 16'h1410);
		cyc(200);
		get(d);
		chk(d[15:0], 16'h1410);
		f_offs <= 4'h0;
		cyc(6);
		chk(16'(clip_ind), 16'h0000);
		get(d);
		chk(d[15:0], 16'h1010);
	endtask : s_offs
	task automatic s_turnon();
		logic [31:0] d;
		@(posedge clk);
		f_open <= 4'h8;
		f_load <= 4'h4;
		put(8'hC0, 8'h10);
		chk(16'(diag_run), 16'h0001);
		wait_run(1'b0);
		f_open <= 4'h0;
		f_load <= 4'h0;
		get(d);
		chk(d[15:0], 16'hC804);
		chk(16'(d[30]), 16'h0001);
		get(d);
		chk(d[15:0], 16'hD010);
		chk(16'(diag_run), 16'h0000);
	endtask : s_turnon
	task automatic s_repeat();
		logic [31:0] d;
		put(8'h40, 8'h10);
		get(d);
		chk(16'(diag_run), 16'h0001);
		wait_run(1'b0);
		get(d);
		chk(16'(diag_run), 16'h0001);
	endtask : s_repeat

	initial begin
		rst_n = 1'b0;
		{f_gnd, f_vcc, f_load, f_open, f_offs, cur_low} = '0;
		therm = 1'b0;
		clip = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		cyc(4);
		chk({cwa, cwb}, 16'h0000);
		chk({15'h0, diag_run}, 16'h0000);
		s_bare();
		s_refuse();
		s_cur();
		s_offs();
		s_turnon();
		s_repeat();
		report_and_stop();
	end
	initial begin
		cyc(90000);
		fail_count++;
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
